// >>> logic/fsp_pkg.sv
package fsp_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_PTR  = 8'h04;
  localparam logic [7:0] OFF_SRC  = 8'h08;
  localparam logic [7:0] OFF_OP   = 8'h0c;
  localparam logic [7:0] OFF_RES  = 8'h10;
  localparam logic [7:0] OFF_STAT = 8'h14;
  localparam int BIT_SE   = 0;
  localparam int BIT_ER   = 1;
  localparam int BIT_WR   = 2;
  localparam int BIT_RFL  = 3;
  localparam int BIT_CLR  = 4;
  localparam int BIT_STORE = 0;
  localparam int BIT_LOAD  = 1;
  localparam logic [4:0] CMD_LOAD  = 5'h01;
  localparam logic [4:0] CMD_ERASE = 5'h03;
  localparam logic [4:0] CMD_WRITE = 5'h05;
  localparam logic [4:0] CMD_FUSE  = 5'h09;
  localparam logic [4:0] CMD_CLEAR = 5'h11;
  localparam logic [4:0] CTRL_RST  = 5'h00;
  // ----------------------------------------------------------------
  // Windows and timing
  // ----------------------------------------------------------------
  localparam logic [2:0] SPM_WIN  = 3'h4;
  localparam logic [2:0] LPM_WIN  = 3'h3;
  localparam logic [2:0] SPM_LAST = 3'h1;
  localparam logic [2:0] LPM_LAST = SPM_WIN - LPM_WIN + SPM_LAST;
  localparam int CLK_MHZ    = 10;
  localparam int OP_MIN_US  = 3700;
  localparam int OP_MAX_US  = 4500;
  localparam int OP_MIN_CYC = OP_MIN_US * CLK_MHZ;
  // ----------------------------------------------------------------
  // Data values
  // ----------------------------------------------------------------
  localparam logic [15:0] PTR_FLOW  = 16'h0000;
  localparam logic [15:0] PTR_LOCK  = 16'h0001;
  localparam logic [15:0] PTR_FHIGH = 16'h0003;
  localparam logic [15:0] WORD_ERASED = 16'hffff;
  localparam logic [5:0]  LOCK_RSVD   = 6'h3f;
  localparam logic [7:0]  BYTE_NONE   = 8'hff;
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} fsp_state_t;
endpackage

// >>> logic/fsp_buf_if.sv
`timescale 1ns/1ns
interface fsp_buf_if #(parameter int WI_W = 5);
  logic            wr;
  logic            clr;
  logic [WI_W-1:0] widx;
  logic [WI_W-1:0] ridx;
  logic [15:0]     wdata;
  logic [15:0]     rdata;
  modport seq   (output wr, clr, widx, ridx, wdata, input rdata);
  modport store (input wr, clr, widx, ridx, wdata, output rdata);
endinterface

// >>> logic/fsp_page_buf.sv
`timescale 1ns/1ns
module fsp_page_buf #(
  parameter int WI_W = 5
) (
  input wire logic pclk,
  input wire logic presetn,
  fsp_buf_if.store bi
);
  import fsp_pkg::*;
  localparam int WORDS = 2 ** WI_W;

  logic [15:0] mem_r [WORDS];

  assign bi.rdata = mem_r[bi.ridx];

  // Slots are written by index, so any load order works.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < WORDS; i++) mem_r[i] <= WORD_ERASED;
    end else if (bi.clr) begin
      for (int i = 0; i < WORDS; i++) mem_r[i] <= WORD_ERASED;
    end else if (bi.wr) begin
      mem_r[bi.widx] <= bi.wdata;
    end
  end
endmodule

// >>> logic/fsp_seq.sv
`timescale 1ns/1ns
module fsp_seq #(
  parameter int WI_W      = 5,
  parameter int PG_W      = 7,
  parameter int OP_CYCLES = fsp_pkg::OP_MIN_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        eeprom_write_busy,
  input  wire logic [7:0]  fuse_low_prog,
  input  wire logic [7:0]  fuse_high_prog,
  input  wire logic [1:0]  lock_prog,
  output logic [14:0]      flash_raddr,
  input  wire logic [15:0] flash_rword,
  output logic             core_halt,
  output logic             flash_erase,
  output logic             flash_write,
  output logic [PG_W-1:0]  flash_page,
  output logic             flash_wvalid,
  output logic [WI_W-1:0]  flash_widx,
  output logic [15:0]      flash_wdata
);
  import fsp_pkg::*;
  localparam int TW = $clog2(OP_CYCLES + 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fsp_state_t      st_r, st_nxt;
  logic [4:0]      ctrl_r, ctrl_nxt;
  logic [2:0]      cnt_r, cnt_nxt;
  logic [15:0]     ptr_r;
  logic [15:0]     src_r;
  logic [7:0]      res_r;
  logic [TW-1:0]   tmr_r;
  logic [WI_W-1:0] sidx_r;
  logic            svld_r;
  logic            ee_q_r;
  logic            rd_pend_r;
  logic            rd_hi_r;
  logic [31:0]     prdata_r;
  logic            pready_r;
  logic            pslverr_r;
  logic            halt_r;
  logic            erase_r;
  logic            write_r;
  logic [PG_W-1:0] page_r;
  logic [14:0]     raddr_r;
  logic            wvalid_r;
  logic [WI_W-1:0] widx_r;
  logic [15:0]     wdata_r;

  fsp_buf_if #(.WI_W(WI_W)) bi ();

  fsp_page_buf #(.WI_W(WI_W)) u_buf (
    .pclk    (pclk),
    .presetn (presetn),
    .bi      (bi)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire        acc      = psel & penable;
  wire        take     = acc & pready_r;
  wire        wr_take  = take & pwrite;
  wire        hit_ctrl = paddr == OFF_CTRL;
  wire        hit_ptr  = paddr == OFF_PTR;
  wire        hit_src  = paddr == OFF_SRC;
  wire        hit_op   = paddr == OFF_OP;
  wire        hit_res  = paddr == OFF_RES;
  wire        hit_stat = paddr == OFF_STAT;
  wire        mapped   = hit_ctrl | hit_ptr | hit_src | hit_op |
                         hit_res | hit_stat;
  wire [4:0]  cmd      = pwdata[4:0];
  wire        cmd_ok   = cmd == CMD_LOAD || cmd == CMD_ERASE ||
                         cmd == CMD_WRITE || cmd == CMD_FUSE ||
                         cmd == CMD_CLEAR;
  wire        idle     = st_r == ST_IDLE;
  wire        armed    = cnt_r != 3'h0;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // A control write during an EEPROM write is dropped entirely.
  wire ctrl_wr  = wr_take & hit_ctrl & cmd_ok & idle &
                  !eeprom_write_busy;
  wire spm_go   = wr_take & hit_op & pwdata[BIT_STORE] & armed &
                  ctrl_r[BIT_SE] & !eeprom_write_busy;
  wire lpm_go   = wr_take & hit_op & pwdata[BIT_LOAD];
  wire fuse_md  = ctrl_r == CMD_FUSE;
  wire fuse_go  = lpm_go & fuse_md & (cnt_r >= LPM_LAST) &
                  !eeprom_write_busy;
  wire lpm_pl   = lpm_go & !fuse_go;
  wire op_ers   = spm_go & (ctrl_r == CMD_ERASE);
  wire op_wrt   = spm_go & (ctrl_r == CMD_WRITE);
  wire op_start = op_ers | op_wrt;
  wire done     = !idle & (tmr_r == TW'(0));
  wire expire   = idle & armed &
                  (cnt_r == (fuse_md ? LPM_LAST : SPM_LAST));
  wire ee_rise  = eeprom_write_busy & !ee_q_r;
  wire [WI_W-1:0] word_idx = ptr_r[WI_W:1];
  wire [PG_W-1:0] page_idx = ptr_r[WI_W+PG_W:WI_W+1];

  // ----------------------------------------------------------------
  // Buffer control
  // ----------------------------------------------------------------
  // A fresh EEPROM write discards whatever was loaded so far.
  assign bi.wr    = spm_go & (ctrl_r == CMD_LOAD);
  assign bi.widx  = word_idx;
  assign bi.wdata = src_r;
  assign bi.clr   = (ctrl_wr & (cmd == CMD_CLEAR)) |
                    (done & (st_r == ST_WRITE)) | ee_rise;
  assign bi.ridx  = sidx_r;

  // ----------------------------------------------------------------
  // Control register and armed window
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_nxt = ctrl_r;
    cnt_nxt  = armed ? cnt_r - 3'h1 : 3'h0;
    if (ctrl_wr) begin
      ctrl_nxt = cmd;
      cnt_nxt  = SPM_WIN;
    end else if (done) begin
      ctrl_nxt = CTRL_RST;
    end else if (op_start) begin
      cnt_nxt  = 3'h0;
    end else if (spm_go || fuse_go || expire) begin
      ctrl_nxt = CTRL_RST;
      cnt_nxt  = 3'h0;
    end
  end

  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      ST_IDLE: begin
        if (op_ers) st_nxt = ST_ERASE;
        else if (op_wrt) st_nxt = ST_WRITE;
      end
      ST_ERASE, ST_WRITE: begin
        if (done) st_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r   <= ST_IDLE;
      ctrl_r <= CTRL_RST;
      cnt_r  <= 3'h0;
      ee_q_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      ctrl_r <= ctrl_nxt;
      cnt_r  <= cnt_nxt;
      ee_q_r <= eeprom_write_busy;
    end
  end

  // ----------------------------------------------------------------
  // Operation timer and flash strobes
  // ----------------------------------------------------------------
  // The timer counts exactly the minimum time at the nominal clock, so a
  // clock running fast ends the operation before the allowed span opens.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tmr_r <= TW'(0);
    end else if (op_start) begin
      tmr_r <= TW'(OP_CYCLES - 1);
    end else if (!idle && !done) begin
      tmr_r <= tmr_r - TW'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_r  <= 1'b0;
      erase_r <= 1'b0;
      write_r <= 1'b0;
      page_r  <= '0;
    end else begin
      halt_r  <= st_nxt != ST_IDLE;
      erase_r <= op_ers;
      write_r <= op_wrt;
      if (op_start) page_r <= page_idx;
    end
  end

  // Buffer words stream out once at the start of a page write.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      svld_r   <= 1'b0;
      sidx_r   <= '0;
      wvalid_r <= 1'b0;
      widx_r   <= '0;
      wdata_r  <= 16'h0000;
    end else begin
      wvalid_r <= svld_r;
      widx_r   <= sidx_r;
      wdata_r  <= bi.rdata;
      if (op_wrt) begin
        svld_r <= 1'b1;
        sidx_r <= '0;
      end else if (svld_r) begin
        svld_r <= sidx_r != '1;
        sidx_r <= sidx_r + WI_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // Load path
  // ----------------------------------------------------------------
  wire [7:0] lock_byte = {LOCK_RSVD, ~lock_prog};
  wire [7:0] fuse_byte = (ptr_r == PTR_FLOW)  ? ~fuse_low_prog :
                         (ptr_r == PTR_LOCK)  ? lock_byte :
                         (ptr_r == PTR_FHIGH) ? ~fuse_high_prog :
                         BYTE_NONE;
  wire [7:0] word_byte = rd_hi_r ? flash_rword[15:8]
                                 : flash_rword[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raddr_r   <= 15'h0000;
      rd_pend_r <= 1'b0;
      rd_hi_r   <= 1'b0;
      res_r     <= 8'h00;
    end else begin
      rd_pend_r <= lpm_pl;
      if (lpm_pl) begin
        raddr_r <= ptr_r[15:1];
        rd_hi_r <= ptr_r[0];
      end
      if (fuse_go) res_r <= fuse_byte;
      else if (rd_pend_r) res_r <= word_byte;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  // The answer is withheld while an operation runs, so a bus access
  // stalls exactly like the halted core would.
  wire [31:0] rd_mux =
    hit_ctrl ? {27'h0, ctrl_r} :
    hit_ptr  ? {16'h0, ptr_r} :
    hit_src  ? {16'h0, src_r} :
    hit_res  ? {24'h0, res_r} :
    hit_stat ? {29'h0, armed, eeprom_write_busy, !idle} :
    32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0;
      pslverr_r <= 1'b0;
      ptr_r     <= 16'h0000;
      src_r     <= 16'h0000;
    end else begin
      pready_r  <= acc & !pready_r & idle;
      if (acc && !pready_r) begin
        prdata_r  <= pwrite ? 32'h0 : rd_mux;
        pslverr_r <= !mapped;
      end
      if (wr_take && hit_ptr) ptr_r <= pwdata[15:0];
      if (wr_take && hit_src) src_r <= pwdata[15:0];
    end
  end

  assign prdata       = prdata_r;
  assign pready       = pready_r;
  assign pslverr      = pslverr_r;
  assign core_halt    = halt_r;
  assign flash_erase  = erase_r;
  assign flash_write  = write_r;
  assign flash_page   = page_r;
  assign flash_raddr  = raddr_r;
  assign flash_wvalid = wvalid_r;
  assign flash_widx   = widx_r;
  assign flash_wdata  = wdata_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  int hcnt_r;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) hcnt_r <= 0;
    else hcnt_r <= halt_r ? hcnt_r + 1 : 0;
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_arm_store;
    ctrl_wr && cmd != CMD_FUSE;
  endsequence
  sequence s_arm_fuse;
    ctrl_wr && cmd == CMD_FUSE;
  endsequence

  chk_store_window: assert property (
    s_arm_store ##1 (!wr_take)[*4] |=> ctrl_r == CTRL_RST)
    else $error("store window did not expire");
  chk_fuse_window: assert property (
    s_arm_fuse ##1 (!wr_take)[*3] |=> ctrl_r == CTRL_RST)
    else $error("fuse window did not expire");
  chk_op_length: assert property (
    $fell(halt_r) |-> hcnt_r == OP_CYCLES)
    else $error("operation length wrong");
  chk_halt_start: assert property (
    op_start |=> halt_r [*8])
    else $error("core not halted");
  chk_enable_held: assert property (
    !idle |-> ctrl_r[BIT_SE] && !armed)
    else $error("enable dropped during operation");
  chk_write_clear: assert property (
    st_r == ST_WRITE && done |-> bi.clr ##1 !halt_r)
    else $error("buffer not cleared after write");
  chk_ee_block: assert property (
    eeprom_write_busy && idle && !expire |=> idle && $stable(ctrl_r))
    else $error("command taken during eeprom write");
  chk_lock_read: assert property (
    fuse_go && ptr_r == PTR_LOCK |=>
      res_r == {LOCK_RSVD, ~$past(lock_prog)})
    else $error("lock byte wrong");
  chk_fuse_low: assert property (
    fuse_go && ptr_r == PTR_FLOW |=> res_r == ~$past(fuse_low_prog))
    else $error("fuse low byte wrong");
  chk_byte_pick: assert property (
    lpm_pl |=> rd_pend_r && rd_hi_r == $past(ptr_r[0]) ##1
      res_r == ($past(rd_hi_r) ? $past(flash_rword[15:8])
                               : $past(flash_rword[7:0])))
    else $error("program byte read wrong");
  chk_bad_cmd: assert property (
    wr_take && hit_ctrl && !cmd_ok |=> cnt_r != SPM_WIN)
    else $error("illegal pattern armed the window");
endmodule

// >>> tb/fsp_flash_model.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Program flash behind the sequencer
// ----------------------------------------------------------------
// Words never written hold an address pattern, so a read of the
// wrong word or the wrong byte shows up at once.
module fsp_flash_model #(
  parameter int WI_W = 5,
  parameter int PG_W = 7
) (
  input  wire logic            pclk,
  input  wire logic [14:0]     flash_raddr,
  output logic      [15:0]     flash_rword,
  input  wire logic            flash_erase,
  input  wire logic [PG_W-1:0] flash_page,
  input  wire logic            flash_wvalid,
  input  wire logic [WI_W-1:0] flash_widx,
  input  wire logic [15:0]     flash_wdata
);
  logic [15:0] mem [int];
  int          upd = 0;

  function automatic logic [15:0] word(input int a);
    return mem.exists(a) ? mem[a] : 16'(a * 40503 + 90);
  endfunction

  always @(posedge pclk) begin
    if (flash_erase === 1'b1) begin
      for (int i = 0; i < (1 << WI_W); i++) begin
        mem[int'({flash_page, WI_W'(i)})] = 16'hffff;
      end
      upd++;
    end
    if (flash_wvalid === 1'b1) begin
      // Programming can only clear bits, as real cells do.
      mem[int'({flash_page, flash_widx})] =
        word(int'({flash_page, flash_widx})) & flash_wdata;
      upd++;
    end
  end

  always @(flash_raddr or upd) begin
    flash_rword = word(int'(flash_raddr));
  end
endmodule

// >>> tb/fsp_seq_tb.sv
`timescale 1ns/1ns
module fsp_seq_tb;
  import fsp_pkg::*;
  localparam int WI_W  = 5;
  localparam int PG_W  = 7;
  // The operation must outlast the write burst, which reads the buffer
  // that is cleared when the operation ends.
  localparam int OPC   = 40;
  localparam int NSLOT = 1 << WI_W;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]      paddr, fuse_low_prog, fuse_high_prog;
  logic [31:0]     pwdata, prdata, rd;
  logic            eeprom_write_busy, err, core_halt, flash_wvalid;
  logic            flash_erase, flash_write;
  logic [1:0]      lock_prog;
  logic [14:0]     flash_raddr;
  logic [15:0]     flash_rword, flash_wdata;
  logic [PG_W-1:0] flash_page, pg_seen;
  logic [WI_W-1:0] flash_widx;
  logic [15:0]     wq[$];
  logic [4:0]      bad[6] = '{5'h02, 5'h04, 5'h07, 5'h0b, 5'h13, 5'h1f};
  int              exp_buf[NSLOT];
  int              sl[$];
  int              failures, n_compared, halt_cnt, er_n, wr_n, pg;
  bit              bus_held;

  fsp_seq #(.WI_W(WI_W), .PG_W(PG_W), .OP_CYCLES(OPC)) fsp_seq_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .eeprom_write_busy(eeprom_write_busy),
    .fuse_low_prog(fuse_low_prog), .fuse_high_prog(fuse_high_prog),
    .lock_prog(lock_prog), .flash_raddr(flash_raddr),
    .flash_rword(flash_rword), .core_halt(core_halt),
    .flash_erase(flash_erase), .flash_write(flash_write),
    .flash_page(flash_page), .flash_wvalid(flash_wvalid),
    .flash_widx(flash_widx), .flash_wdata(flash_wdata));

  fsp_flash_model #(.WI_W(WI_W), .PG_W(PG_W)) fsp_flash_model_i (
    .pclk(pclk), .flash_raddr(flash_raddr), .flash_rword(flash_rword),
    .flash_erase(flash_erase), .flash_page(flash_page),
    .flash_wvalid(flash_wvalid), .flash_widx(flash_widx),
    .flash_wdata(flash_wdata));

  always #50 pclk = ~pclk;

  // ----------------------------------------------------------------
  // Flash side monitor
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (core_halt === 1'b1) halt_cnt++;
    if (flash_erase === 1'b1) er_n++;
    if (flash_write === 1'b1) wr_n++;
    if (flash_erase === 1'b1 || flash_write === 1'b1) pg_seen = flash_page;
    if (flash_wvalid === 1'b1) begin
      chk(32'(flash_widx), 32'(wq.size()));
      wq.push_back(flash_wdata);
    end
  end

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // A held bus lets the next setup follow the access at once, which
  // the three-cycle fuse window needs.
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input bit m);
    int n;
    n = 0;
    if (!bus_held) @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      if (++n > 200) begin
        failures++;
        final_report();
      end
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    penable <= 1'b0;
    if (!m) psel <= 1'b0;
    bus_held = m;
  endtask

  task automatic w(input logic [7:0] a, input logic [31:0] d,
                   input bit m = 1'b0);
    apb(1'b1, a, d, m);
  endtask

  task automatic rck(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, 1'b0);
    chk(rd, e);
  endtask

  task automatic issue(input logic [15:0] p, input logic [4:0] c,
                       input logic [15:0] src);
    w(OFF_PTR, 32'(p));
    w(OFF_SRC, 32'(src));
    apb(1'b0, OFF_STAT, 32'h0, 1'b0);
    chk(32'(rd[1]), 32'(eeprom_write_busy));
    w(OFF_CTRL, 32'(c), 1'b1);
    w(OFF_OP, 32'h1);
  endtask

  task automatic load(input int s, input logic [15:0] d);
    issue(16'((pg << (WI_W + 1)) | (s << 1) | ($urandom & 1)),
          CMD_LOAD, d);
    exp_buf[s] = d;
  endtask

  task automatic page_op(input logic [4:0] c);
    int n;
    n = 0;
    halt_cnt = 0;
    er_n = 0;
    wr_n = 0;
    wq.delete();
    issue(16'(pg << (WI_W + 1)), c, 16'($urandom));
    apb(1'b0, OFF_STAT, 32'h0, 1'b0);
    while (c == CMD_WRITE && wq.size() < NSLOT) begin
      if (++n > 100) begin
        failures++;
        final_report();
      end
      @(posedge pclk);
    end
    repeat (2) @(posedge pclk);
    chk(halt_cnt, OPC);
    chk(32'(pg_seen), 32'(pg));
    chk(er_n, c == CMD_ERASE);
    chk(wr_n, c == CMD_WRITE);
    rck(OFF_CTRL, 32'h0);
    if (c == CMD_WRITE) begin
      for (int i = 0; i < NSLOT; i++) begin
        chk(32'(wq[i]), 32'(exp_buf[i]));
        exp_buf[i] = 'hffff;
      end
    end
  endtask

  task automatic fuse(input logic [15:0] p, input logic [31:0] e);
    w(OFF_PTR, 32'(p));
    w(OFF_CTRL, 32'(CMD_FUSE), 1'b1);
    w(OFF_OP, 32'h2);
    rck(OFF_RES, e);
    rck(OFF_CTRL, 32'h0);
  endtask

  function automatic logic [31:0] byte_at(input logic [15:0] p);
    logic [15:0] wd;
    wd = fsp_flash_model_i.word(int'(p[15:1]));
    return {24'h0, p[0] ? wd[15:8] : wd[7:0]};
  endfunction

  task automatic plain(input logic [15:0] p);
    w(OFF_PTR, 32'(p));
    w(OFF_OP, 32'h2);
    rck(OFF_RES, byte_at(p));
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    eeprom_write_busy = 1'b0;
    void'($urandom(26573));
    fuse_low_prog = 8'($urandom);
    fuse_high_prog = 8'($urandom);
    lock_prog = 2'($urandom);
    foreach (exp_buf[i]) exp_buf[i] = 'hffff;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rck(OFF_CTRL, 32'h0);
    w(OFF_RES, 32'hff);
    rck(OFF_RES, 32'h0);
    apb(1'b0, 8'h20, 32'h0, 1'b0);
    chk(32'(err), 32'h1);
    fuse(PTR_FLOW, {24'h0, ~fuse_low_prog});
    fuse(PTR_LOCK, {24'h0, LOCK_RSVD, ~lock_prog});
    fuse(PTR_FHIGH, {24'h0, ~fuse_high_prog});
    for (int i = 0; i < 4; i++) plain(16'($urandom));
    pg = $urandom_range(1, (1 << PG_W) - 1);
    for (int i = 0; i < NSLOT; i++) sl.push_back(i);
    sl.shuffle();
    foreach (sl[i]) load(sl[i], 16'($urandom));
    page_op(CMD_ERASE);
    page_op(CMD_WRITE);
    // Clearing by command, by EEPROM write and by reset must each leave only erased words.
    for (int k = 0; k < 3; k++) begin
      load(k + 3, 16'h0);
      halt_cnt = 0;
      if (k == 0) issue(16'h0, CMD_CLEAR, 16'h0);
      if (k == 1) begin
        eeprom_write_busy <= 1'b1;
        issue(16'h0, CMD_ERASE, 16'h0);
        chk(halt_cnt, 0);
        fuse(PTR_FLOW, byte_at(16'h0));
        eeprom_write_busy <= 1'b0;
      end
      if (k == 2) begin
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
      end
      exp_buf[k + 3] = 'hffff;
      page_op(CMD_WRITE);
    end
    foreach (bad[i]) begin
      halt_cnt = 0;
      issue(16'h0, bad[i], 16'h0);
      rck(OFF_CTRL, 32'h0);
      chk(halt_cnt, 0);
    end
    halt_cnt = 0;
    w(OFF_PTR, 32'h0);
    w(OFF_CTRL, 32'(CMD_ERASE));
    repeat (2) @(posedge pclk);
    w(OFF_OP, 32'h1);
    rck(OFF_CTRL, 32'h0);
    chk(halt_cnt, 0);
    final_report();
  end
endmodule
